/* hw/uflc_pkg.sv */
// shared constants and types for the serial flow, request and baud control block
package uflc_pkg;
	// fifo geometry
	localparam int FIFO_DEPTH = 16;
	localparam int SKID_DEPTH = 2;
	localparam logic [4:0] FIFO_CAP = 5'h10;
	localparam logic [4:0] HOLD_CAP = 5'h01;
	// handshake thresholds in free bytes
	localparam logic [4:0] RTS_ON_FREE = 5'h02;
	localparam logic [4:0] RTS_OFF_FREE = 5'h01;
	localparam int HS_CHANNELS = 2;
	// request routing modes
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_INT = 2'h1;
	localparam logic [1:0] MODE_DMA = 2'h2;
	// error status bit positions
	localparam int ERR_W = 4;
	localparam int ERR_OVR = 0;
	localparam int ERR_PAR = 1;
	localparam int ERR_FRM = 2;
	localparam int ERR_BRK = 3;
	// frame and timing figures
	localparam logic [3:0] START_BITS = 4'h1;
	localparam logic [3:0] MIN_DATA_BITS = 4'h5;
	localparam logic [3:0] STOP_BITS = 4'h1;
	localparam logic [8:0] TO_WORDS = 9'h003;
	localparam logic [8:0] OVERSAMPLE = 9'h010;
	localparam logic [3:0] SUB_LAST = 4'hf;
	// reset values
	localparam logic [15:0] DIV_RST = 16'h0000;
	localparam logic [4:0] CNT_RST = 5'h00;
	// break sequencer, gray along idle, wait, send
	typedef enum logic [1:0] {
		BRK_IDLE = 2'b00,
		BRK_WAIT = 2'b01,
		BRK_SEND = 2'b11
	} uflc_brk_t;
endpackage : uflc_pkg

/* hw/uflc_skid.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module uflc_skid import uflc_pkg::*; #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] mem [SKID_DEPTH];
	logic wp_q;
	logic rp_q;
	logic [1:0] cnt_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// full and empty straight from the count, so a stalled drain really fills it
	assign in_ready = (cnt_q != 2'(SKID_DEPTH));
	assign out_valid = (cnt_q != 2'h0);
	assign out_data = mem[rp_q];

	// storage needs no reset, it is only read while counted
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_q] <= in_data;
		end
	end

	// pointers and occupancy
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			wp_q <= wp_q ^ push;
			rp_q <= rp_q ^ pop;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : uflc_skid

/* hw/uflc_baud.sv */
// baud generator: source by divisor plus one gives the 16x tick, then by 16 the bit tick
`timescale 1ns/100ps
module uflc_baud import uflc_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// configuration
	input wire logic clk_sel,
	input wire logic ext_baud_clk,
	input wire logic [15:0] baud_divisor,
	// ticks
	output logic tick16,
	output logic bit_tick
);
	logic ext_q;
	logic [15:0] div_q;
	logic [3:0] sub_q;
	// external clock is counted by its rising edges, so it must run slower than clk
	wire src_tick = clk_sel ? (ext_baud_clk && !ext_q) : 1'b1;
	wire div_wrap = src_tick && (div_q == 16'h0000);

	// divisor counter and 16x prescaler
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ext_q <= 1'b0;
			div_q <= DIV_RST;
			sub_q <= 4'h0;
			tick16 <= 1'b0;
			bit_tick <= 1'b0;
		end else begin
			ext_q <= ext_baud_clk;
			if (src_tick) begin
				div_q <= div_wrap ? baud_divisor : div_q - 16'h0001;
			end
			if (div_wrap) begin
				sub_q <= sub_q + 4'h1;
			end
			tick16 <= div_wrap;
			bit_tick <= div_wrap && (sub_q == SUB_LAST);
		end
	end
endmodule : uflc_baud

/* hw/uflc_core.sv */
// serial channel control: flow control, request routing, error fifo, break, loopback
`timescale 1ns/100ps
module uflc_core import uflc_pkg::*; #(
	parameter int CHAN = 0
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// channel configuration
	input wire logic fifo_en,
	input wire logic [1:0] rx_mode,
	input wire logic [1:0] tx_mode,
	input wire logic rx_err_irq_en,
	input wire logic rx_timeout_en,
	input wire logic loopback,
	input wire logic send_break,
	input wire logic [4:0] rx_trig_lvl,
	input wire logic [4:0] tx_trig_lvl,
	input wire logic [1:0] word_len,
	input wire logic parity_en,
	input wire logic two_stop,
	// baud source
	input wire logic clk_sel,
	input wire logic ext_baud_clk,
	input wire logic [15:0] baud_divisor,
	output logic baud16_tick,
	output logic baud_bit_tick,
	// modem lines and their control
	input wire logic auto_handshake,
	input wire logic modem_ctrl_reg,
	input wire logic tx_permit_in_n,
	output logic rx_room_out_n,
	output logic modem_stat_reg,
	// receive shifter side
	input wire logic rx_word_valid,
	input wire logic [7:0] rx_word,
	input wire logic rx_par_err,
	input wire logic rx_frm_err,
	input wire logic rx_brk,
	// software receive side
	input wire logic rd_pop,
	output logic [7:0] rx_data_reg,
	input wire logic err_stat_rd,
	output logic [ERR_W-1:0] rx_error_reg,
	output logic [4:0] rx_count,
	// software transmit side
	input wire logic tx_wr_valid,
	output logic tx_wr_ready,
	input wire logic [7:0] tx_wr_data,
	output logic [4:0] tx_count,
	// transmit shifter side
	input wire logic tx_busy,
	input wire logic tx_serial,
	output logic tx_load,
	output logic [7:0] tx_word,
	// serial pins
	input wire logic rxd_pin,
	output logic txd_pin,
	output logic rx_serial,
	// status and requests
	output logic [2:0] txrx_stat_reg,
	output logic rx_irq,
	output logic tx_irq,
	output logic err_irq,
	output logic rx_dma_req,
	output logic tx_dma_req
);
	localparam bit HAS_HS = (CHAN < HS_CHANNELS);

	// request routing by mode, bit 1 dma, bit 0 interrupt
	function automatic logic [1:0] route(input logic [1:0] mode, input logic ev);
		route = {ev && (mode == MODE_DMA), ev && (mode == MODE_INT)};
	endfunction : route

	logic [7:0] rx_mem [FIFO_DEPTH];
	logic [ERR_W-1:0] rx_err_mem [FIFO_DEPTH];
	logic [7:0] tx_mem [FIFO_DEPTH];
	logic [3:0] rx_wp_q, rx_rp_q, tx_wp_q, tx_rp_q;
	logic [4:0] rx_cnt_q, tx_cnt_q;
	logic cts_s1_q, cts_s2_q;
	logic head_rep_q, char_rd_q, seen_q;
	logic [ERR_W-1:0] err_stat_q;
	logic [8:0] to_cnt_q;
	logic to_done_q;
	logic [3:0] brk_bits_q;
	uflc_brk_t brk_q;
	logic sk_valid;
	logic [7:0] sk_data;

	// shared decodes
	wire auto_on = HAS_HS && auto_handshake;
	wire [4:0] cap = fifo_en ? FIFO_CAP : HOLD_CAP;
	wire [3:0] word_bits = START_BITS + MIN_DATA_BITS + {2'b00, word_len} + STOP_BITS;
	wire [3:0] frame_bits = word_bits + {3'b000, parity_en} + {3'b000, two_stop};

	// receive fifo control; a pop frees room for a push in the same cycle
	wire rx_full = (rx_cnt_q >= cap);
	wire rx_pop_ok = rd_pop && (rx_cnt_q != CNT_RST);
	wire rx_push_ok = rx_word_valid && (!rx_full || rx_pop_ok);
	wire rx_ovr = rx_word_valid && rx_full && !rx_pop_ok;
	wire [4:0] rx_cnt_d = rx_cnt_q + {4'h0, rx_push_ok} - {4'h0, rx_pop_ok};
	wire [ERR_W-1:0] new_err = {rx_brk, rx_frm_err, rx_par_err, 1'b0};
	wire [ERR_W-1:0] head_err = (rx_cnt_q != CNT_RST) ? rx_err_mem[rx_rp_q] : '0;
	wire rx_hit = fifo_en ? (rx_cnt_d == rx_trig_lvl) : 1'b1;
	wire rx_ev = rx_push_ok && rx_hit;

	// one error event per flagged entry, raised when it reaches the head
	wire err_fire = (|head_err) && !head_rep_q;
	wire char_done = char_rd_q || (rx_pop_ok && head_rep_q);
	wire seen_done = seen_q || (err_stat_rd && (|err_stat_q));
	wire err_clr = char_done && seen_done;

	// time-out watch: fifo holds data below trigger and nothing moves
	wire [8:0] to_limit = TO_WORDS * {5'h00, word_bits} * OVERSAMPLE;
	wire to_arm = fifo_en && rx_timeout_en && (rx_cnt_q != CNT_RST) && (rx_cnt_q < rx_trig_lvl);
	wire rx_move = rx_push_ok || rx_pop_ok;
	wire to_ev = to_arm && !to_done_q && !rx_move && baud16_tick
		&& (to_cnt_q == to_limit - 9'h001);

	// transmit fifo; loads wait for the shifter, a pending break and clear-to-send
	wire tx_push = sk_valid && (tx_cnt_q < cap);
	wire cts_ok = !auto_on || cts_s2_q;
	wire tx_pop = (tx_cnt_q != CNT_RST) && !tx_busy && !tx_load && (brk_q == BRK_IDLE)
		&& !send_break && cts_ok;
	wire [4:0] tx_cnt_d = tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
	wire tx_ev = tx_pop && (fifo_en ? (tx_cnt_d == tx_trig_lvl) : 1'b1);
	wire [1:0] rx_route = route(rx_mode, rx_ev);
	wire [1:0] tx_route = route(tx_mode, tx_ev);
	wire line = (brk_q == BRK_SEND) ? 1'b0 : tx_serial;
	wire [4:0] rx_free = FIFO_CAP - rx_cnt_q;

	// write buffer absorbs software writes while the fifo is full
	uflc_skid #(.W(8)) u_skid (
		.clk(clk),
		.nrst(nrst),
		.in_valid(tx_wr_valid),
		.in_ready(tx_wr_ready),
		.in_data(tx_wr_data),
		.out_valid(sk_valid),
		.out_ready(tx_cnt_q < cap),
		.out_data(sk_data)
	);

	uflc_baud u_baud (
		.clk(clk),
		.nrst(nrst),
		.clk_sel(clk_sel),
		.ext_baud_clk(ext_baud_clk),
		.baud_divisor(baud_divisor),
		.tick16(baud16_tick),
		.bit_tick(baud_bit_tick)
	);

	// fifo storage, overrun marks the newest stored entry
	always_ff @(posedge clk) begin
		if (rx_push_ok) begin
			rx_mem[rx_wp_q] <= rx_word;
			rx_err_mem[rx_wp_q] <= new_err;
		end else if (rx_ovr) begin
			rx_err_mem[rx_wp_q - 4'h1][ERR_OVR] <= 1'b1;
		end
		if (tx_push) begin
			tx_mem[tx_wp_q] <= sk_data;
		end
	end

	// pointers, counts and read data
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_wp_q <= 4'h0;
			rx_rp_q <= 4'h0;
			rx_cnt_q <= CNT_RST;
			tx_wp_q <= 4'h0;
			tx_rp_q <= 4'h0;
			tx_cnt_q <= CNT_RST;
			rx_data_reg <= 8'h00;
			tx_word <= 8'h00;
			tx_load <= 1'b0;
		end else begin
			rx_wp_q <= rx_wp_q + {3'h0, rx_push_ok};
			rx_rp_q <= rx_rp_q + {3'h0, rx_pop_ok};
			rx_cnt_q <= rx_cnt_d;
			tx_wp_q <= tx_wp_q + {3'h0, tx_push};
			tx_rp_q <= tx_rp_q + {3'h0, tx_pop};
			tx_cnt_q <= tx_cnt_d;
			if (rx_pop_ok) begin
				rx_data_reg <= rx_mem[rx_rp_q];
			end
			if (tx_pop) begin
				tx_word <= tx_mem[tx_rp_q];
			end
			tx_load <= tx_pop;
		end
	end

	// error status: a new head error wins over a clear in the same cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			head_rep_q <= 1'b0;
			char_rd_q <= 1'b0;
			seen_q <= 1'b0;
			err_stat_q <= '0;
		end else begin
			head_rep_q <= rx_pop_ok ? 1'b0 : (head_rep_q || err_fire);
			char_rd_q <= err_clr ? 1'b0 : char_done;
			seen_q <= err_clr ? 1'b0 : seen_done;
			err_stat_q <= (err_clr ? '0 : err_stat_q) | (err_fire ? head_err : '0);
		end
	end
	assign rx_error_reg = err_stat_q;

	// time-out counter restarts on any fifo movement
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			to_cnt_q <= 9'h000;
			to_done_q <= 1'b0;
		end else begin
			if (rx_move || !to_arm) begin
				to_cnt_q <= 9'h000;
			end else if (baud16_tick) begin
				to_cnt_q <= to_cnt_q + 9'h001;
			end
			to_done_q <= rx_move ? 1'b0 : (to_done_q || to_ev);
		end
	end

	// break sequencer; extra tick covers the partial first bit period
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			brk_q <= BRK_IDLE;
			brk_bits_q <= 4'h0;
		end else begin
			case (brk_q)
				BRK_IDLE: begin
					if (send_break) begin
						brk_q <= BRK_WAIT;
					end
				end
				BRK_WAIT: begin
					if (!tx_busy && !tx_load) begin
						brk_q <= BRK_SEND;
						brk_bits_q <= frame_bits;
					end
				end
				BRK_SEND: begin
					if (baud_bit_tick) begin
						brk_bits_q <= brk_bits_q - 4'h1;
						if (brk_bits_q == 4'h0) begin
							brk_q <= BRK_IDLE;
						end
					end
				end
				default: begin
					brk_q <= BRK_IDLE;
				end
			endcase
		end
	end

	// modem lines, serial path, status and requests all leave from flops
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cts_s1_q <= 1'b0;
			cts_s2_q <= 1'b0;
			rx_room_out_n <= 1'b1;
			txd_pin <= 1'b1;
			rx_serial <= 1'b1;
			txrx_stat_reg <= 3'b110;
			rx_irq <= 1'b0;
			tx_irq <= 1'b0;
			err_irq <= 1'b0;
			rx_dma_req <= 1'b0;
			tx_dma_req <= 1'b0;
		end else begin
			cts_s1_q <= !tx_permit_in_n;
			cts_s2_q <= cts_s1_q;
			if (!HAS_HS) begin
				rx_room_out_n <= 1'b1;
			end else if (!auto_on) begin
				rx_room_out_n <= !modem_ctrl_reg;
			end else if (rx_free > RTS_ON_FREE) begin
				rx_room_out_n <= 1'b0;
			end else if (rx_free < RTS_OFF_FREE) begin
				rx_room_out_n <= 1'b1;
			end
			txd_pin <= loopback ? 1'b1 : line;
			rx_serial <= loopback ? line : rxd_pin;
			txrx_stat_reg <= {!tx_busy && !tx_load && (brk_q == BRK_IDLE),
				tx_cnt_q == CNT_RST, rx_cnt_q != CNT_RST};
			rx_irq <= rx_route[0] || to_ev;
			rx_dma_req <= rx_route[1];
			tx_irq <= tx_route[0];
			tx_dma_req <= tx_route[1];
			err_irq <= err_fire && rx_err_irq_en;
		end
	end
	assign modem_stat_reg = cts_s2_q;
	assign rx_count = rx_cnt_q;
	assign tx_count = tx_cnt_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_rx_hit;
		fifo_en && (rx_mode == MODE_INT) && rx_push_ok && (rx_cnt_d == rx_trig_lvl);
	endsequence
	sequence s_brk_armed;
		(brk_q == BRK_WAIT) && tx_busy;
	endsequence

	a_no_hs_chan: assert property (!HAS_HS |-> rx_room_out_n)
		else $error("request-to-send driven on a channel without handshake");
	a_cts_gates_tx: assert property (tx_load && auto_on |-> $past(cts_s2_q))
		else $error("transmitter loaded without clear-to-send");
	a_rts_full_off: assert property (auto_on && rx_cnt_q == FIFO_CAP |=> rx_room_out_n)
		else $error("request-to-send active with no free byte");
	a_rts_room_on: assert property (auto_on && rx_free > RTS_ON_FREE |=> !rx_room_out_n)
		else $error("request-to-send inactive with room to spare");
	a_err_irq_gate: assert property (err_irq |-> $past(rx_err_irq_en) && $past(|head_err))
		else $error("error interrupt without enable or flagged head");
	a_rx_trig_irq: assert property (s_rx_hit |=> rx_irq)
		else $error("no rx interrupt at trigger level");
	a_tx_hold_irq: assert property (!fifo_en && tx_mode == MODE_INT && tx_pop |=> tx_irq)
		else $error("no tx interrupt on holding register load");
	a_dma_replace: assert property (tx_mode == MODE_DMA && tx_ev |=> tx_dma_req && !tx_irq)
		else $error("dma mode did not replace the tx interrupt");
	a_brk_line_low: assert property (brk_q == BRK_SEND && !loopback |=> !txd_pin)
		else $error("serial output not low during break");
	a_loop_feeds: assert property (loopback |=> rx_serial == $past(line) && txd_pin)
		else $error("loopback did not feed the receiver");
	a_brk_waits: assert property (s_brk_armed |=> brk_q != BRK_SEND)
		else $error("break started during a character");
	a_one_err_evt: assert property (err_irq |=> !err_irq)
		else $error("more than one error interrupt for one entry");
endmodule : uflc_core

/* tb/uflc_peer.sv */
// peer model: clear-to-send source and transmit shifter stand-in
`timescale 1ns/100ps
module uflc_peer #(
	parameter int BIT_CYC = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// handshake toward the channel
	input wire logic peer_room,
	output logic tx_permit_in_n,
	// shifter stand-in
	input wire logic tx_load,
	input wire logic [7:0] tx_word,
	output logic tx_busy,
	output logic tx_serial
);
	logic [9:0] sh_q;
	logic [7:0] cnt_q;
	// the peer grants only while its own fifo has room
	assign tx_permit_in_n = ~peer_room;
	assign tx_serial = sh_q[0];
	// start, eight data lsb first, stop; the line idles high between frames
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sh_q <= 10'h3ff;
			cnt_q <= 8'h00;
			tx_busy <= 1'b0;
		end else if (tx_load) begin
			sh_q <= {1'b1, tx_word, 1'b0};
			cnt_q <= 8'(10 * BIT_CYC);
			tx_busy <= 1'b1;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
			tx_busy <= (cnt_q != 8'h01);
			if ((int'(cnt_q) % BIT_CYC) == 1) begin
				sh_q <= {1'b1, sh_q[9:1]};
			end
		end
	end
endmodule : uflc_peer

/* tb/tb.sv */
// self-checking bench for the serial flow, request and baud control block
`timescale 1ns/100ps
module tb import uflc_pkg::*;;
	logic clk, nrst, fifo_en, rx_err_irq_en, rx_timeout_en, loopback, send_break;
	logic [1:0] rx_mode, tx_mode, word_len;
	logic [4:0] rx_trig_lvl, tx_trig_lvl, rx_count, tx_count;
	logic parity_en, two_stop, clk_sel, ext_baud_clk, baud16_tick, baud_bit_tick;
	logic [15:0] baud_divisor;
	logic auto_handshake, modem_ctrl_reg, tx_permit_in_n, rx_room_out_n, modem_stat_reg;
	logic rx_word_valid, rx_par_err, rx_frm_err, rx_brk, rd_pop, err_stat_rd;
	logic [7:0] rx_word, rx_data_reg, tx_wr_data, tx_word;
	logic [ERR_W-1:0] rx_error_reg;
	logic tx_wr_valid, tx_wr_ready, tx_busy, tx_serial, tx_load, peer_room;
	logic rxd_pin, txd_pin, rx_serial, rx_irq, tx_irq, err_irq, rx_dma_req, tx_dma_req;
	logic [2:0] txrx_stat_reg;
	logic [7:0] evs;
	logic [7:0] q[$];
	int err_total, n_tests, cyc_n, t16, tbit, gap16, gapbit, ext_cnt, n;
	int ev[8];
	int base[8];

	uflc_core #(.CHAN(0)) uflc_core_i (.clk, .nrst, .fifo_en, .rx_mode, .tx_mode,
		.rx_err_irq_en, .rx_timeout_en, .loopback, .send_break, .rx_trig_lvl, .tx_trig_lvl,
		.word_len, .parity_en, .two_stop, .clk_sel, .ext_baud_clk, .baud_divisor,
		.baud16_tick, .baud_bit_tick, .auto_handshake, .modem_ctrl_reg, .tx_permit_in_n,
		.rx_room_out_n, .modem_stat_reg, .rx_word_valid, .rx_word, .rx_par_err, .rx_frm_err,
		.rx_brk, .rd_pop, .rx_data_reg, .err_stat_rd, .rx_error_reg, .rx_count,
		.tx_wr_valid, .tx_wr_ready, .tx_wr_data, .tx_count, .tx_busy, .tx_serial, .tx_load,
		.tx_word, .rxd_pin, .txd_pin, .rx_serial, .txrx_stat_reg, .rx_irq, .tx_irq, .err_irq,
		.rx_dma_req, .tx_dma_req);
	uflc_peer #(.BIT_CYC(4)) uflc_peer_i (.clk, .nrst, .peer_room, .tx_permit_in_n,
		.tx_load, .tx_word, .tx_busy, .tx_serial);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// external baud source at a sixth of clk, kept slower than the system clock
	always @(posedge clk) begin
		ext_cnt = (ext_cnt == 2) ? 0 : ext_cnt + 1;
		if (ext_cnt == 0) ext_baud_clk <= ~ext_baud_clk;
	end

	// event tallies on the edge, so every one-cycle pulse is counted once
	assign evs = {tx_load, ~txd_pin, ~rx_serial, tx_dma_req, rx_dma_req, err_irq, tx_irq, rx_irq};
	always @(posedge clk) begin
		cyc_n++;
		for (int i = 0; i < 8; i++) if (evs[i] === 1'b1) ev[i]++;
		if (tx_load === 1'b1) q.push_back(tx_word);
		if (baud16_tick === 1'b1) begin
			gap16 = cyc_n - t16;
			t16 = cyc_n;
		end
		if (baud_bit_tick === 1'b1) begin
			gapbit = cyc_n - tbit;
			tbit = cyc_n;
		end
	end

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// event count since the last mark
	task automatic chk_ev(input string nm, input int i, input int exp);
		chk(nm, 16'(exp), 16'(ev[i] - base[i]));
	endtask : chk_ev

	// snapshot away from the edge so the tally process never races it
	task automatic mark();
		@(negedge clk);
		base = ev;
	endtask : mark

	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask : cyc

	// hold valid and data until ready is seen at the taking edge
	task automatic tx_write(input logic [7:0] d);
		@(posedge clk);
		tx_wr_valid <= 1'b1;
		tx_wr_data <= d;
		@(negedge clk);
		for (int i = 0; i < 400 && tx_wr_ready !== 1'b1; i++) @(negedge clk);
		@(posedge clk);
		tx_wr_valid <= 1'b0;
	endtask : tx_write

	// one word from the receive shifter, e is {break, frame, parity}
	task automatic rx_push(input logic [7:0] d, input logic [2:0] e);
		@(posedge clk);
		rx_word_valid <= 1'b1;
		rx_word <= d;
		{rx_brk, rx_frm_err, rx_par_err} <= e;
		@(posedge clk);
		rx_word_valid <= 1'b0;
		{rx_brk, rx_frm_err, rx_par_err} <= 3'h0;
	endtask : rx_push

	// pop a character and compare it, or read the error status
	task automatic rd(input logic pop, input logic [7:0] exp);
		@(posedge clk);
		rd_pop <= pop;
		err_stat_rd <= ~pop;
		@(posedge clk);
		rd_pop <= 1'b0;
		err_stat_rd <= 1'b0;
		@(negedge clk);
		if (pop) chk("rx_data", {8'h00, exp}, {8'h00, rx_data_reg});
	endtask : rd

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done

	// the sequence takes under ten thousand cycles
	initial begin
		repeat (40000) @(posedge clk);
		err_total++;
		test_done();
	end

	initial begin
		nrst = 1'b0;
		{fifo_en, rx_err_irq_en, rx_timeout_en, loopback, send_break} = 5'h18;
		{rx_mode, tx_mode, word_len} = {MODE_INT, MODE_INT, 2'h3};
		{rx_trig_lvl, tx_trig_lvl} = {5'h04, 5'h01};
		{parity_en, two_stop, clk_sel, ext_baud_clk} = 4'h0;
		baud_divisor = 16'h0001;
		{auto_handshake, modem_ctrl_reg, peer_room, rxd_pin} = 4'h9;
		{rx_word_valid, rx_word, rx_par_err, rx_frm_err, rx_brk} = 12'h000;
		{rd_pop, err_stat_rd, tx_wr_valid, tx_wr_data} = 11'h000;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("rst_lines", 16'h00f9, {8'h00, rx_room_out_n, txd_pin, rx_serial,
			txrx_stat_reg, modem_stat_reg, tx_wr_ready});
		chk("rst_counts", 16'h0000, {6'h00, rx_count, tx_count});
		@(posedge clk);
		nrst <= 1'b1;
		// peer has no room: words wait, then leave once the synced grant lands
		mark();
		tx_write(8'h11);
		tx_write(8'h22);
		cyc(10);
		chk("tx_count", 16'h0002, {11'h0, tx_count});
		chk_ev("tx_load_held", 7, 0);
		@(posedge clk);
		peer_room <= 1'b1;
		cyc(2);
		chk("cts_sync1", 16'h0, {15'h0, modem_stat_reg});
		cyc(1);
		chk("cts_sync2", 16'h1, {15'h0, modem_stat_reg});
		cyc(100);
		chk_ev("tx_load", 7, 2);
		chk_ev("tx_irq_trig", 1, 1);
		chk("tx_words", 16'h1122, {q[$-1], q[$]});
		chk("tx_idle_stat", 16'h6, {13'h0, txrx_stat_reg});
		// holding mode: every shifter load is an event, routed by the mode
		for (int m = 0; m < 3; m++) begin
			@(posedge clk);
			fifo_en <= 1'b0;
			tx_mode <= 2'(m);
			mark();
			tx_write(8'h30);
			tx_write(8'h31);
			cyc(120);
			chk_ev("tx_irq", 1, m == 1 ? 2 : 0);
			chk_ev("tx_dma", 4, m == 2 ? 2 : 0);
		end
		// fifo mode receive: the push reaching the trigger level is the event
		for (int m = 0; m < 3; m++) begin
			@(posedge clk);
			fifo_en <= 1'b1;
			rx_mode <= 2'(m);
			mark();
			for (int i = 0; i < 4; i++) rx_push(8'(8'h40 + i), 3'h0);
			cyc(3);
			chk_ev("rx_irq", 0, m == 1 ? 1 : 0);
			chk_ev("rx_dma", 3, m == 2 ? 1 : 0);
			chk("rx_ready", 16'h1, {15'h0, txrx_stat_reg[0]});
			for (int i = 0; i < 4; i++) rd(1'b1, 8'(8'h40 + i));
		end
		// fill to the brim: request-to-send drops, overrun marks the newest entry
		mark();
		for (int i = 0; i < 14; i++) rx_push(8'(i), 3'h0);
		cyc(3);
		chk("rts_free2", 16'h0, {15'h0, rx_room_out_n});
		rx_push(8'h0e, 3'h0);
		rx_push(8'h0f, 3'h0);
		cyc(3);
		chk("rts_full", 16'h1, {15'h0, rx_room_out_n});
		rx_push(8'hee, 3'h0);
		cyc(3);
		chk("rx_count", 16'h10, {11'h0, rx_count});
		for (int i = 0; i < 15; i++) rd(1'b1, 8'(i));
		cyc(3);
		chk("rts_free15", 16'h0, {15'h0, rx_room_out_n});
		chk_ev("err_ovr_irq", 2, 1);
		chk("err_ovr", 16'(1 << ERR_OVR), {12'h0, rx_error_reg});
		rd(1'b1, 8'h0f);
		rd(1'b0, 8'h00);
		cyc(3);
		chk("err_clr", 16'h0, {12'h0, rx_error_reg});
		// errors wait in the status fifo until their character reaches the head
		mark();
		rx_push(8'h0a, 3'h0);
		rx_push(8'h0b, 3'h2);
		rx_push(8'h0c, 3'h0);
		rx_push(8'h0d, 3'h1);
		rx_push(8'h0e, 3'h0);
		cyc(3);
		chk_ev("err_early", 2, 0);
		rd(1'b1, 8'h0a);
		cyc(3);
		chk_ev("err_head", 2, 1);
		chk("err_frm", 16'(1 << ERR_FRM), {12'h0, rx_error_reg});
		rd(1'b0, 8'h00);
		chk("err_hold", 16'(1 << ERR_FRM), {12'h0, rx_error_reg});
		rd(1'b1, 8'h0b);
		cyc(3);
		chk("err_clr2", 16'h0, {12'h0, rx_error_reg});
		@(posedge clk);
		rx_err_irq_en <= 1'b0;
		rd(1'b1, 8'h0c);
		cyc(3);
		chk_ev("err_masked", 2, 1);
		chk("err_par", 16'(1 << ERR_PAR), {12'h0, rx_error_reg});
		rd(1'b1, 8'h0d);
		rd(1'b0, 8'h00);
		rd(1'b1, 8'h0e);
		// holding mode: coinciding errors give one interrupt
		@(posedge clk);
		fifo_en <= 1'b0;
		rx_mode <= MODE_INT;
		rx_err_irq_en <= 1'b1;
		mark();
		rx_push(8'h5c, 3'h7);
		cyc(3);
		chk_ev("hold_err_irq", 2, 1);
		chk("hold_err", 16'h000e, {12'h0, rx_error_reg});
		rd(1'b1, 8'h5c);
		rd(1'b0, 8'h00);
		rx_push(8'h5d, 3'h0);
		rd(1'b1, 8'h5d);
		cyc(1);
		chk_ev("hold_rx_irq", 0, 2);
		// a lone word below the trigger times out after three word times
		@(posedge clk);
		fifo_en <= 1'b1;
		rx_timeout_en <= 1'b1;
		rx_mode <= MODE_OFF;
		mark();
		rx_push(8'h77, 3'h0);
		cyc(900);
		chk_ev("to_early", 0, 0);
		cyc(200);
		chk_ev("to_fire", 0, 1);
		cyc(1100);
		chk_ev("to_once", 0, 1);
		rd(1'b1, 8'h77);
		// software handshake: request-to-send follows the modem control bit
		@(posedge clk);
		auto_handshake <= 1'b0;
		rx_timeout_en <= 1'b0;
		modem_ctrl_reg <= (rx_count < 5'h0f);
		cyc(3);
		chk("rts_sw_on", 16'h0, {15'h0, rx_room_out_n});
		// software drops its request only once the count has reached 15
		for (int i = 0; i < 15; i++) rx_push(8'(i), 3'h0);
		@(posedge clk);
		modem_ctrl_reg <= (rx_count < 5'h0f);
		cyc(3);
		chk("rts_sw_off", 16'h1, {15'h0, rx_room_out_n});
		for (int i = 0; i < 15; i++) rd(1'b1, 8'(i));
		// baud: divisor plus one source ticks per sixteenth, sixteen per bit
		@(posedge clk);
		baud_divisor <= 16'h0003;
		cyc(300);
		chk("gap16", 16'h4, 16'(gap16));
		chk("gapbit", 16'h40, 16'(gapbit));
		@(posedge clk);
		clk_sel <= 1'b1;
		baud_divisor <= 16'h0001;
		cyc(600);
		chk("gap16_ext", 16'hc, 16'(gap16));
		chk("gapbit_ext", 16'hc0, 16'(gapbit));
		// loopback: the stream turns round inside and the pin stays idle
		@(posedge clk);
		clk_sel <= 1'b0;
		loopback <= 1'b1;
		mark();
		chk("cts_stat", 16'h1, {15'h0, modem_stat_reg});
		tx_write(8'h0f);
		cyc(80);
		chk_ev("lb_rx_low", 5, 20);
		chk_ev("lb_txd_low", 6, 0);
		// break waits out the character on the wire, lasts a frame, then data resumes
		@(posedge clk);
		loopback <= 1'b0;
		mark();
		tx_write(8'hff);
		cyc(12);
		@(posedge clk);
		send_break <= 1'b1;
		@(posedge clk);
		send_break <= 1'b0;
		tx_write(8'h5a);
		cyc(8);
		chk("txd_mid_char", 16'h1, {15'h0, txd_pin});
		cyc(200);
		chk("txd_break", 16'h0, {15'h0, txd_pin});
		chk_ev("ld_in_break", 7, 1);
		cyc(400);
		n = ev[6] - base[6] - 24;
		chk("break_len", 16'h1, 16'(n >= 320 && n <= 353));
		chk_ev("ld_after", 7, 2);
		chk("last_word", 16'h5a, {8'h00, q[$]});
		// short word with parity and two stops: the break follows the frame length
		@(posedge clk);
		{word_len, parity_en, two_stop} <= 4'h3;
		mark();
		@(posedge clk);
		send_break <= 1'b1;
		@(posedge clk);
		send_break <= 1'b0;
		cyc(500);
		n = ev[6] - base[6];
		chk("break_len2", 16'h1, 16'(n >= 288 && n <= 321));
		test_done();
	end
endmodule : tb
